// *** design/status_indicator_defines.svh ***
// Constants for the receiver indicator driver
// Assumes inclusion by the package and the driver module
`ifndef STATUS_INDICATOR_DEFINES_SVH
`define STATUS_INDICATOR_DEFINES_SVH

// AXI4-Lite register byte offsets
`define REG_MODE_OFFSET 12'h000
`define REG_STATUS_OFFSET 12'h004
`define REG_IRQ_STATUS_OFFSET 12'h008
`define REG_IRQ_MASK_OFFSET 12'h00c

// Mode register reset value (factory mode)
`define MODE_RESET 3'h0

// Interrupt event bit positions
`define IRQ_BIT_LOCKOUT 0
`define IRQ_BIT_FAULT 1
`define IRQ_BIT_OUTPUT_OFF 2
`define IRQ_BIT_MODE_WRITE 3
`define IRQ_WIDTH 4

// Blink half period in milliseconds and clock rate
`define BLINK_HALF_MS 250
`define CLOCK_HZ 125000000

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** design/status_indicator_pkg.sv ***
// Types for the receiver indicator driver
// Assumes the defines header is on the include path
`include "status_indicator_defines.svh"

package status_indicator_pkg;

    // Lamp colour for two-colour lamps
    typedef enum logic [1:0] {
        lamp_off_type_v = 2'b00,
        lamp_green_v = 2'b01,
        lamp_red_v = 2'b10,
        lamp_orange_v = 2'b11
    } lamp_colour_type;

    // Sensor core status inputs
    typedef struct packed {
        logic safety_output_pair;
        logic top_block_light;
        logic top_end_light;
        logic bottom_block_light;
        logic bottom_end_light;
        logic stable_light;
        logic unstable_light;
        logic internal_fault;
        logic lockout;
        logic sourcing_polarity;
        logic sinking_polarity;
        logic controller_connected;
        logic blanking_enabled;
        logic interlock_active;
        logic mute_in_a;
        logic mute_in_b;
        logic mpi_input;
        logic muting_active;
    } core_status_type;

    // Lamp drive outputs, two bits per two-colour lamp and one bit per single lamp
    typedef struct packed {
        lamp_colour_type top_alignment;
        lamp_colour_type bottom_alignment;
        lamp_colour_type safety_output;
        lamp_colour_type light_stability_lamp;
        lamp_colour_type multi_purpose;
        logic fault_lamp;
        logic error_display_enable;
        logic sourcing_lamp;
        logic sinking_lamp;
        logic function_lamp;
        logic interlock_lamp;
        logic mute_in_a_lamp;
        logic mute_in_b_lamp;
    } lamp_drive_type;

endpackage

// *** design/status_indicator_driver.sv ***
// Receiver lamp driver with an AXI4-Lite register slave
// Assumes status inputs are asynchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
`include "status_indicator_defines.svh"

module status_indicator_driver #(
    parameter int blink_half_cycles = (`BLINK_HALF_MS * (`CLOCK_HZ / 1000))
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire status_indicator_pkg::core_status_type core_status,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output status_indicator_pkg::lamp_drive_type lamps,
    output logic irq
);
    import status_indicator_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    core_status_type sync_a;
    core_status_type sync_b;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= core_status;
            sync_b <= sync_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared blink generator

    logic [31:0] blink_count;
    logic blink;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            blink_count <= 32'h0;
            blink <= 1'b0;
        end else if (blink_count >= 32'(blink_half_cycles - 1)) begin
            blink_count <= 32'h0;
            blink <= ~blink;
        end else begin
            blink_count <= blink_count + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register slave

    logic [2:0] mode;
    logic [`IRQ_WIDTH-1:0] irq_status;
    logic [`IRQ_WIDTH-1:0] irq_mask;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [`IRQ_WIDTH-1:0] irq_clear;
    logic [`IRQ_WIDTH-1:0] irq_event;
    logic mode_written;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `REG_MODE_OFFSET, `REG_IRQ_STATUS_OFFSET, `REG_IRQ_MASK_OFFSET: begin
                        s_axi_bresp <= `RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign mode_written = do_write && aw_addr == `REG_MODE_OFFSET && w_strb[0];
    assign irq_clear = (do_write && aw_addr == `REG_IRQ_STATUS_OFFSET && w_strb[0])
        ? w_data[`IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode <= `MODE_RESET;
        end else if (mode_written) begin
            mode <= w_data[2:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_mask <= '0;
        end else if (do_write && aw_addr == `REG_IRQ_MASK_OFFSET && w_strb[0]) begin
            irq_mask <= w_data[`IRQ_WIDTH-1:0];
        end
    end

    // Read channel
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                case (s_axi_araddr)
                    `REG_MODE_OFFSET: s_axi_rdata <= {29'h0, mode};
                    `REG_STATUS_OFFSET: s_axi_rdata <= {14'h0, sync_b};
                    `REG_IRQ_STATUS_OFFSET: s_axi_rdata <= {28'h0, irq_status};
                    `REG_IRQ_MASK_OFFSET: s_axi_rdata <= {28'h0, irq_mask};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events

    logic lockout_prev;
    logic fault_prev;
    logic output_prev;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lockout_prev <= 1'b0;
            fault_prev <= 1'b0;
            output_prev <= 1'b0;
        end else begin
            lockout_prev <= sync_b.lockout;
            fault_prev <= sync_b.internal_fault;
            output_prev <= sync_b.safety_output_pair;
        end
    end

    assign irq_event[`IRQ_BIT_LOCKOUT] = sync_b.lockout && !lockout_prev;
    assign irq_event[`IRQ_BIT_FAULT] = sync_b.internal_fault && !fault_prev;
    assign irq_event[`IRQ_BIT_OUTPUT_OFF] = !sync_b.safety_output_pair && output_prev;
    assign irq_event[`IRQ_BIT_MODE_WRITE] = mode_written;

    // Set wins over clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            irq <= |(((irq_status & ~irq_clear) | irq_event) & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lamp decode

    lamp_colour_type mpi_on;
    lamp_colour_type mpi_off;

    // Multi-purpose lamp, colour for input active and inactive per mode
    always_comb begin
        mpi_on = lamp_off_type_v;
        mpi_off = lamp_off_type_v;
        case (mode)
            3'h0: begin mpi_on = lamp_red_v; mpi_off = lamp_green_v; end
            3'h1: begin mpi_on = blink ? lamp_red_v : lamp_off_type_v; mpi_off = blink ? lamp_green_v : lamp_off_type_v; end
            3'h2: begin mpi_on = lamp_red_v; mpi_off = blink ? lamp_green_v : lamp_off_type_v; end
            3'h3: begin mpi_on = blink ? lamp_red_v : lamp_off_type_v; mpi_off = lamp_green_v; end
            3'h4: begin mpi_on = lamp_red_v; mpi_off = blink ? lamp_red_v : lamp_off_type_v; end
            3'h5: begin mpi_on = blink ? lamp_green_v : lamp_off_type_v; mpi_off = lamp_green_v; end
            3'h6: begin
                mpi_on = sync_b.safety_output_pair ? lamp_green_v : lamp_red_v;
                mpi_off = mpi_on;
                if (sync_b.muting_active) begin
                    mpi_on = blink ? lamp_green_v : lamp_off_type_v;
                    mpi_off = mpi_on;
                end
            end
            default: begin
                mpi_on = lamp_red_v;
                mpi_off = blink ? lamp_red_v : lamp_off_type_v;
                if (sync_b.muting_active) begin
                    mpi_on = blink ? lamp_green_v : lamp_off_type_v;
                    mpi_off = mpi_on;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lamps <= '0;
        end else begin
            if (sync_b.safety_output_pair) begin
                lamps.top_alignment <= lamp_green_v;
            end else if (sync_b.top_end_light) begin
                lamps.top_alignment <= blink ? lamp_red_v : lamp_off_type_v;
            end else if (sync_b.top_block_light) begin
                lamps.top_alignment <= lamp_red_v;
            end else begin
                lamps.top_alignment <= lamp_off_type_v;
            end
            if (sync_b.safety_output_pair) begin
                lamps.bottom_alignment <= lamp_green_v;
            end else if (sync_b.bottom_end_light) begin
                lamps.bottom_alignment <= blink ? lamp_red_v : lamp_off_type_v;
            end else if (sync_b.bottom_block_light) begin
                lamps.bottom_alignment <= lamp_red_v;
            end else begin
                lamps.bottom_alignment <= lamp_off_type_v;
            end
            lamps.safety_output <= sync_b.safety_output_pair ? lamp_green_v : lamp_red_v;
            if (sync_b.stable_light) begin
                lamps.light_stability_lamp <= lamp_green_v;
            end else if (sync_b.unstable_light) begin
                lamps.light_stability_lamp <= lamp_orange_v;
            end else begin
                lamps.light_stability_lamp <= lamp_off_type_v;
            end
            lamps.multi_purpose <= sync_b.mpi_input ? mpi_on : mpi_off;
            lamps.fault_lamp <= sync_b.internal_fault;
            lamps.error_display_enable <= sync_b.lockout;
            lamps.sourcing_lamp <= sync_b.sourcing_polarity;
            lamps.sinking_lamp <= sync_b.sinking_polarity;
            lamps.function_lamp <= sync_b.controller_connected ? blink : sync_b.blanking_enabled;
            lamps.interlock_lamp <= sync_b.interlock_active;
            lamps.mute_in_a_lamp <= sync_b.mute_in_a;
            lamps.mute_in_b_lamp <= sync_b.mute_in_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_safety_lamp_colour: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> lamps.safety_output == ($past(sync_b.safety_output_pair) ? lamp_green_v : lamp_red_v))
        else $error("safety lamp colour wrong");

    a_bottom_green: assert property (@(posedge sys_clk) disable iff (rst)
        sync_b.safety_output_pair |=> lamps.bottom_alignment == lamp_green_v)
        else $error("bottom segment not green");

    a_bottom_blink: assert property (@(posedge sys_clk) disable iff (rst)
        (!sync_b.safety_output_pair && sync_b.bottom_end_light)
        |=> lamps.bottom_alignment == ($past(blink) ? lamp_red_v : lamp_off_type_v))
        else $error("bottom blink wrong");

    a_top_block_red: assert property (@(posedge sys_clk) disable iff (rst)
        (!sync_b.safety_output_pair && !sync_b.top_end_light && sync_b.top_block_light)
        |=> lamps.top_alignment == lamp_red_v)
        else $error("top segment not red");

    a_fault_lamp: assert property (@(posedge sys_clk) disable iff (rst)
        lamps.fault_lamp == $past(sync_b.internal_fault))
        else $error("fault lamp mismatch");

    a_error_display: assert property (@(posedge sys_clk) disable iff (rst)
        lamps.error_display_enable |-> $past(sync_b.lockout))
        else $error("error shown outside lockout");

    a_function_steady: assert property (@(posedge sys_clk) disable iff (rst)
        (!sync_b.controller_connected && sync_b.blanking_enabled) |=> lamps.function_lamp)
        else $error("function lamp not steady");

    sequence s_mode_write;
        mode_written ##1 1'b1;
    endsequence

    a_mode_update: assert property (@(posedge sys_clk) disable iff (rst)
        s_mode_write |-> mode == $past(w_data[2:0]))
        else $error("mode not updated");

    a_blink_period: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(blink) |-> blink_count == 32'h0 && $past(blink_count) == 32'(blink_half_cycles - 1))
        else $error("blink phase off");

endmodule // status_indicator_driver
`default_nettype wire

// *** tb/core_status_model.sv ***
// Sensor core model that drives the status levels
// Assumes the bench sets the wanted status just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module core_status_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire status_indicator_pkg::core_status_type want,
    output var status_indicator_pkg::core_status_type core_status
);
    import status_indicator_pkg::*;
    ////////////////////////////////////////
    // Status levels change only on an edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core_status <= '0;
        end else begin
            core_status <= want;
        end
    end
endmodule // core_status_model
`default_nettype wire

// *** tb/status_indicator_driver_tb.sv ***
// Self-checking bench for the receiver lamp driver
// Assumes the design package and defines are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "status_indicator_defines.svh"
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; $display("[FAIL] %0t %s", $time, "mismatch"); end end
module status_indicator_driver_tb;
    import status_indicator_pkg::*;
    typedef struct packed {
        logic [18:0] eo;
        logic [18:0] ea;
        logic [18:0] co;
        logic [18:0] ca;
    } obs_note_type;
    localparam int half = 4;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    core_status_type want = '0;
    core_status_type core_status;
    core_status_type s;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    lamp_drive_type lamps;
    logic irq;
    logic [33:0] bus_q[$];
    logic [33:0] exp_bus;
    obs_note_type lamp_q[$];
    obs_note_type n_note;
    logic [18:0] o_or, o_and;
    logic ph_bad;
    event obs_ev;
    int errors = 0;
    int n_tests = 0;
    int seed = 45;
    ////////////////////////////////////////
    core_status_model partner (.sys_clk(sys_clk), .rst(rst), .want(want), .core_status(core_status));
    status_indicator_driver #(.blink_half_cycles(half)) dut (
        .sys_clk(sys_clk), .rst(rst), .core_status(core_status),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lamps(lamps), .irq(irq));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    // Segment colour when lit and when dark
    function automatic logic [3:0] seg(input logic on, input logic e, input logic b);
        if (on) return {lamp_green_v, lamp_green_v};
        if (e) return {lamp_red_v, lamp_off_type_v};
        if (b) return {lamp_red_v, lamp_red_v};
        return 4'h0;
    endfunction
    // Multi-purpose colour, lit and dark halves, per mode
    function automatic logic [3:0] mpi(input logic [2:0] m, input core_status_type c);
        logic [1:0] k;
        logic bl;
        if (c.mpi_input) begin
            k = (m == 3'h5) ? lamp_green_v : lamp_red_v;
            bl = m == 3'h1 || m == 3'h3 || m == 3'h5;
        end else begin
            k = (m == 3'h4 || m == 3'h7) ? lamp_red_v : lamp_green_v;
            bl = m == 3'h1 || m == 3'h2 || m == 3'h4 || m == 3'h7;
        end
        if (m == 3'h6) begin
            k = c.safety_output_pair ? lamp_green_v : lamp_red_v;
            bl = 1'b0;
        end
        if (m[2:1] == 2'b11 && c.muting_active) begin
            k = lamp_green_v;
            bl = 1'b1;
        end
        return {k, bl ? 2'b00 : k};
    endfunction
    function automatic obs_note_type lamp_note(input core_status_type c, input logic [2:0] m);
        logic [3:0] t;
        logic [3:0] b;
        logic [3:0] mp;
        logic [1:0] sf;
        logic [1:0] st;
        logic [7:0] lo;
        obs_note_type n;
        t = seg(c.safety_output_pair, c.top_end_light, c.top_block_light);
        b = seg(c.safety_output_pair, c.bottom_end_light, c.bottom_block_light);
        sf = c.safety_output_pair ? lamp_green_v : lamp_red_v;
        st = c.stable_light ? lamp_green_v : (c.unstable_light ? lamp_orange_v : lamp_off_type_v);
        mp = mpi(m, c);
        lo = {c.internal_fault, c.lockout, c.sourcing_polarity, c.sinking_polarity,
              c.controller_connected | c.blanking_enabled, c.interlock_active, c.mute_in_a, c.mute_in_b};
        n.eo = {1'b0, t[3:2], b[3:2], sf, st, mp[3:2], lo};
        lo[7] = 1'b0;
        lo[3] = !c.controller_connected & c.blanking_enabled;
        n.ea = {1'b0, t[1:0], b[1:0], sf, st, mp[1:0], lo};
        n.co = 19'h7ffff;
        n.ca = 19'h7ff7f;
        return n;
    endfunction
    function automatic obs_note_type irq_note(input logic v);
        return {{v, 18'h0}, {v, 18'h0}, 19'h40000, 19'h40000};
    endfunction
    ////////////////////////////////////////
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] strb,
                             input logic [1:0] resp);
        @(posedge sys_clk);
        bus_q.push_back({resp, 32'h0});
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [11:0] a, input logic [33:0] e);
        @(posedge sys_clk);
        bus_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask
    // Collects lamps over one whole blink period
    task automatic observe(input obs_note_type n, input logic both);
        logic [18:0] v;
        lamp_q.push_back(n);
        repeat (6) @(posedge sys_clk);
        o_or = '0;
        o_and = '1;
        ph_bad = 1'b0;
        repeat (2 * half) begin
            @(posedge sys_clk);
            v = {irq, lamps};
            o_or = o_or | v;
            o_and = o_and & v;
            if (both && (lamps.top_alignment !== lamps.bottom_alignment)) ph_bad = 1'b1;
        end
        -> obs_ev;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            exp_bus = bus_q.pop_front();
            `CHECK(s_axi_bresp, exp_bus[33:32])
        end
        if (s_axi_rvalid && s_axi_rready) begin
            exp_bus = bus_q.pop_front();
            `CHECK({s_axi_rresp, s_axi_rdata}, exp_bus)
        end
    end
    always @(obs_ev) begin
        n_note = lamp_q.pop_front();
        `CHECK(o_or & n_note.co, n_note.eo & n_note.co)
        `CHECK(o_and & n_note.ca, n_note.ea & n_note.ca)
        `CHECK(ph_bad, 1'b0)
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        axi_read(`REG_MODE_OFFSET, 34'h0);
        for (int m = 0; m < 8; m++) begin
            axi_write(`REG_MODE_OFFSET, 32'(m), 4'hf, `RESP_OKAY);
            axi_read(`REG_MODE_OFFSET, {`RESP_OKAY, 32'(m)});
        end
        axi_write(`REG_MODE_OFFSET, 32'h2, 4'h0, `RESP_OKAY);
        axi_read(`REG_MODE_OFFSET, {`RESP_OKAY, 32'h7});
        axi_write(`REG_STATUS_OFFSET, 32'h1, 4'hf, `RESP_SLVERR);
        axi_read(12'h010, {`RESP_SLVERR, 32'h0});
        $display("test registers done");
        for (int i = 0; i < 48; i++) begin
            s = (i == 0) ? 18'h0 : 18'($random(seed));
            if (s.stable_light) s.unstable_light = 1'b0;
            axi_write(`REG_MODE_OFFSET, 32'(i % 8), 4'hf, `RESP_OKAY);
            want <= s;
            observe(lamp_note(s, 3'(i % 8)), s.top_end_light & s.bottom_end_light & !s.safety_output_pair);
            axi_read(`REG_STATUS_OFFSET, {`RESP_OKAY, 14'h0, s});
        end
        $display("test lamps done");
        s = '0;
        s.safety_output_pair = 1'b1;
        want <= s;
        repeat (8) @(posedge sys_clk);
        axi_write(`REG_IRQ_STATUS_OFFSET, 32'hf, 4'hf, `RESP_OKAY);
        axi_read(`REG_IRQ_STATUS_OFFSET, 34'h0);
        s = '0;
        s.internal_fault = 1'b1;
        s.lockout = 1'b1;
        want <= s;
        repeat (8) @(posedge sys_clk);
        axi_read(`REG_IRQ_STATUS_OFFSET, {`RESP_OKAY, 32'h7});
        axi_write(`REG_IRQ_MASK_OFFSET, 32'h2, 4'hf, `RESP_OKAY);
        observe(irq_note(1'b1), 1'b0);
        axi_write(`REG_IRQ_MASK_OFFSET, 32'h8, 4'hf, `RESP_OKAY);
        observe(irq_note(1'b0), 1'b0);
        axi_write(`REG_MODE_OFFSET, 32'h0, 4'hf, `RESP_OKAY);
        observe(irq_note(1'b1), 1'b0);
        axi_write(`REG_IRQ_STATUS_OFFSET, 32'hf, 4'hf, `RESP_OKAY);
        observe(irq_note(1'b0), 1'b0);
        axi_read(`REG_IRQ_STATUS_OFFSET, 34'h0);
        $display("test interrupts done");
        end_of_test();
    end
endmodule // status_indicator_driver_tb
`default_nettype wire
